/* File: rtl/apdu_pkg.sv */
// package: register map, field positions and reset values of the align/power/update block
`default_nettype none
package apdu_pkg;
  // printed offsets are not all multiples of four: kept as indices, byte address is four times
  localparam logic [9:0] APDU_IDX_PWR_CTRL = 10'h230;
  localparam logic [9:0] APDU_IDX_UPDATE = 10'h232;
  localparam logic [11:0] APDU_ADDR_PWR_CTRL = {APDU_IDX_PWR_CTRL, 2'b00};
  localparam logic [11:0] APDU_ADDR_UPDATE = {APDU_IDX_UPDATE, 2'b00};
  // field positions
  localparam int APDU_BIT_ALIGN_PD = 2;
  localparam int APDU_BIT_REF_PD = 1;
  localparam int APDU_BIT_SOFT_ALIGN = 0;
  localparam int APDU_BIT_UPDATE_ALL = 0;
  // reset values
  localparam logic [2:0] APDU_PWR_CTRL_RST = 3'h0;
  localparam logic [2:0] APDU_BUF_RST = 3'h0;
  // the update-all bit stays set this many cycles plus one while the copy runs
  localparam logic [1:0] APDU_UPDATE_CYCLES = 2'h1;
  // bus state of the slave
  typedef enum logic [0:0] {
    APDU_BUS_IDLE = 1'b0,
    APDU_BUS_DATA = 1'b1
  } apdu_bus_st_t;
endpackage : apdu_pkg
`default_nettype wire

/* File: rtl/apdu_align_ctrl.sv */
// module: alignment hold and trigger from the software alignment bit
`default_nettype none
module apdu_align_ctrl
  import apdu_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic soft_align_i,
  input wire logic align_pd_i,
  input wire logic [NUM_CH-1:0] align_sel_i,
  output logic [NUM_CH-1:0] ch_static_o,
  output logic align_start_o
);
  initial begin
    if (NUM_CH < 1) $error("NUM_CH must be at least 1");
  end

  typedef struct packed {
    logic prev;
    logic start;
    logic [NUM_CH-1:0] stat;
  } apdu_al_state_t;

  apdu_al_state_t st;
  apdu_al_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // hold selected channels while bit high, pulse on falling edge
  always_comb begin
    next_st = st;
    next_st.prev = soft_align_i;
    next_st.start = st.prev & ~soft_align_i & ~align_pd_i;
    for (int i = 0; i < NUM_CH; i++) begin
      next_st.stat[i] = soft_align_i & align_sel_i[i] & ~align_pd_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ch_static_o = st.stat;
  assign align_start_o = st.start;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_fall;
    soft_align_i ##1 !soft_align_i;
  endsequence

  property p_align_start;
    @(posedge clk_i) disable iff (sys_rst_i)
      (s_fall ##0 !align_pd_i) |=> align_start_o;
  endproperty
  a_align_start: assert property (p_align_start)
    else $error("falling soft align bit did not start alignment");

  property p_no_spurious;
    @(posedge clk_i) disable iff (sys_rst_i)
      align_start_o |-> $past(soft_align_i, 2) && !$past(soft_align_i);
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("alignment started without a falling edge");

  property p_hold_static;
    @(posedge clk_i) disable iff (sys_rst_i)
      (soft_align_i && !align_pd_i) |=> (ch_static_o == $past(align_sel_i));
  endproperty
  a_hold_static: assert property (p_hold_static)
    else $error("selected channels not held static");
endmodule : apdu_align_ctrl
`default_nettype wire

/* File: rtl/apdu_regs.sv */
// module: AHB-Lite register bank for align power-down, soft align and update-all
//
// Operation
// - bit 2 at 0x230 set powers down alignment circuitry; zero by default.
// - bit 1 at 0x230 set powers down distribution reference; zero by default.
// - bit 0 at 0x230 is soft alignment, inverse polarity of the alignment pin.
// - while soft alignment bit is high, selected channels are held static.
// - falling edge of soft alignment bit starts one alignment event.
// - soft alignment bit resets to 0 so outputs run freely.
// - writing 1 to bit 0 at 0x232 copies buffer registers to active ones.
// - update-all bit clears itself once the copy has been made.
`default_nettype none
module apdu_regs
  import apdu_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic align_pin_n_i,
  input wire logic [NUM_CH-1:0] align_sel_i,
  output logic align_pd_o,
  output logic ref_pd_o,
  output logic [NUM_CH-1:0] ch_static_o,
  output logic align_start_o,
  output logic update_pulse_o
);
  initial begin
    if (NUM_CH < 1 || NUM_CH > 32) $error("NUM_CH out of range 1..32");
  end

  typedef struct packed {
    apdu_bus_st_t bus;
    logic wr;
    logic [11:0] addr;
    logic [2:0] buf_ctrl;
    logic [2:0] act_ctrl;
    logic update;
    logic [1:0] upd_cnt;
    logic upd_pulse;
    logic [31:0] rdata;
  } apdu_state_t;

  apdu_state_t st;
  apdu_state_t next_st;
  logic soft_align_eff;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave, buffer writes and update-all copy
  always_comb begin
    next_st = st;
    next_st.upd_pulse = 1'b0;
    // data phase of a control write lands in the buffer, an update write arms the copy
    if (st.bus == APDU_BUS_DATA) begin
      next_st.bus = APDU_BUS_IDLE;
      if (st.wr && st.addr == APDU_ADDR_PWR_CTRL) begin
        next_st.buf_ctrl = hwdata_i[2:0];
      end
      if (st.wr && st.addr == APDU_ADDR_UPDATE && hwdata_i[APDU_BIT_UPDATE_ALL]) begin
        next_st.update = 1'b1;
        next_st.upd_cnt = APDU_UPDATE_CYCLES;
      end
    end
    // copy buffer to active, then self-clear
    if (st.update) begin
      if (st.upd_cnt == 2'h0) begin
        next_st.act_ctrl = st.buf_ctrl;
        next_st.update = 1'b0;
        next_st.upd_pulse = 1'b1;
      end else begin
        next_st.upd_cnt = st.upd_cnt - 2'h1;
      end
    end
    // address phase
    if (hsel_i && hready_i && htrans_i[1]) begin
      next_st.bus = APDU_BUS_DATA;
      next_st.wr = hwrite_i;
      next_st.addr = haddr_i[11:0];
      next_st.rdata = 32'h0000_0000;
      if (!hwrite_i && haddr_i[11:0] == APDU_ADDR_PWR_CTRL) begin
        next_st.rdata = {29'h0, st.buf_ctrl};
      end else if (!hwrite_i && haddr_i[11:0] == APDU_ADDR_UPDATE) begin
        next_st.rdata = {31'h0, st.update};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.buf_ctrl <= APDU_BUF_RST;
      st.act_ctrl <= APDU_PWR_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  // soft bit is the pin inverted: either asserts alignment hold
  assign soft_align_eff = st.act_ctrl[APDU_BIT_SOFT_ALIGN] | ~align_pin_n_i;

  ////////////////////////////////////////////////////////////////////////////
  // alignment channel control
  apdu_align_ctrl #(
    .NUM_CH(NUM_CH)
  ) u_align (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .soft_align_i(soft_align_eff),
    .align_pd_i(st.act_ctrl[APDU_BIT_ALIGN_PD]),
    .align_sel_i(align_sel_i),
    .ch_static_o(ch_static_o),
    .align_start_o(align_start_o)
  );

  // outputs straight from flip-flops, ready and response tied to constants
  assign hrdata_o = st.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign align_pd_o = st.act_ctrl[APDU_BIT_ALIGN_PD];
  assign ref_pd_o = st.act_ctrl[APDU_BIT_REF_PD];
  assign update_pulse_o = st.upd_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_reset_free;
    @(posedge clk_i) sys_rst_i |=> (!align_pd_o && !ref_pd_o && !st.act_ctrl[0]);
  endproperty
  a_reset_free: assert property (p_reset_free)
    else $error("control bits not clear after reset");

  sequence s_upd_write;
    st.bus == APDU_BUS_DATA && st.wr && st.addr == APDU_ADDR_UPDATE && hwdata_i[0];
  endsequence

  property p_update_copy;
    @(posedge clk_i) disable iff (sys_rst_i)
      (s_upd_write ##0 st.update == 1'b0) |=> st.update ##2 (!st.update && update_pulse_o);
  endproperty
  a_update_copy: assert property (p_update_copy)
    else $error("update-all bit did not self-clear on time");

  property p_active_change;
    @(posedge clk_i) disable iff (sys_rst_i)
      (st.act_ctrl != $past(st.act_ctrl)) |-> update_pulse_o;
  endproperty
  a_active_change: assert property (p_active_change)
    else $error("active register changed without update-all");

  property p_pd_follows;
    @(posedge clk_i) disable iff (sys_rst_i)
      update_pulse_o |-> (align_pd_o == $past(st.buf_ctrl[2]) && ref_pd_o == $past(st.buf_ctrl[1]));
  endproperty
  a_pd_follows: assert property (p_pd_follows)
    else $error("power-down bits not copied from buffer");

  property p_ref_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      !update_pulse_o |-> $stable(ref_pd_o);
  endproperty
  a_ref_hold: assert property (p_ref_hold)
    else $error("reference power-down changed outside update");

  property p_pin_equiv;
    @(posedge clk_i) disable iff (sys_rst_i)
      (st.act_ctrl[0] && !align_pd_o) |=> (ch_static_o == $past(align_sel_i));
  endproperty
  a_pin_equiv: assert property (p_pin_equiv)
    else $error("soft align bit did not act as pin low");

  // bus always answers okay
  property p_okay;
    @(posedge clk_i) disable iff (sys_rst_i)
      hresp_o == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus response not okay");
  // no wait states inserted
  property p_no_wait;
    @(posedge clk_i) disable iff (sys_rst_i)
      hreadyout_o == 1'b1;
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("slave inserted a wait state");
  // control read returns the buffer word
  property p_rd_ctrl;
    @(posedge clk_i) disable iff (sys_rst_i)
      (hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[11:0] == APDU_ADDR_PWR_CTRL)
        |=> (hrdata_o == {29'h0, $past(st.buf_ctrl)});
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl)
    else $error("control read data wrong");
  // update read shows the pending bit
  property p_rd_upd;
    @(posedge clk_i) disable iff (sys_rst_i)
      (hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[11:0] == APDU_ADDR_UPDATE)
        |=> (hrdata_o == {31'h0, $past(st.update)});
  endproperty
  a_rd_upd: assert property (p_rd_upd)
    else $error("update read data wrong");
  // unmapped words read zero
  property p_rd_unmapped;
    @(posedge clk_i) disable iff (sys_rst_i)
      (hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[11:0] != APDU_ADDR_UPDATE
        && haddr_i[11:0] != APDU_ADDR_PWR_CTRL) |=> (hrdata_o == 32'h0000_0000);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  // control write lands in the buffer
  property p_buf_write;
    @(posedge clk_i) disable iff (sys_rst_i)
      (st.bus == APDU_BUS_DATA && st.wr && st.addr == APDU_ADDR_PWR_CTRL)
        |=> (st.buf_ctrl == $past(hwdata_i[2:0]));
  endproperty
  a_buf_write: assert property (p_buf_write)
    else $error("control write did not reach buffer");
  // copy strobe lasts one cycle
  property p_pulse_single;
    @(posedge clk_i) disable iff (sys_rst_i)
      update_pulse_o |=> !update_pulse_o;
  endproperty
  a_pulse_single: assert property (p_pulse_single)
    else $error("update strobe longer than one cycle");
  // copy only follows a pending update
  property p_pulse_needs_update;
    @(posedge clk_i) disable iff (sys_rst_i)
      update_pulse_o |-> $past(st.update);
  endproperty
  a_pulse_needs_update: assert property (p_pulse_needs_update)
    else $error("copy without pending update");
  // reference bit copied on update
  property p_ref_copy;
    @(posedge clk_i) disable iff (sys_rst_i)
      update_pulse_o |-> (ref_pd_o == $past(st.buf_ctrl[APDU_BIT_REF_PD]));
  endproperty
  a_ref_copy: assert property (p_ref_copy)
    else $error("reference power-down not copied");
  // alignment power-down only moves on update
  property p_align_pd_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      !update_pulse_o |-> $stable(align_pd_o);
  endproperty
  a_align_pd_hold: assert property (p_align_pd_hold)
    else $error("alignment power-down changed outside update");
  // soft bit only moves on update
  property p_soft_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      !update_pulse_o |-> $stable(st.act_ctrl[APDU_BIT_SOFT_ALIGN]);
  endproperty
  a_soft_hold: assert property (p_soft_hold)
    else $error("soft align bit changed outside update");
  // powered-down alignment never starts
  property p_pd_blocks_start;
    @(posedge clk_i) disable iff (sys_rst_i)
      align_pd_o |=> !align_start_o;
  endproperty
  a_pd_blocks_start: assert property (p_pd_blocks_start)
    else $error("alignment started while powered down");
  // powered-down alignment holds nothing
  property p_pd_blocks_static;
    @(posedge clk_i) disable iff (sys_rst_i)
      align_pd_o |=> (ch_static_o == '0);
  endproperty
  a_pd_blocks_static: assert property (p_pd_blocks_static)
    else $error("channels held while powered down");
  // pin low holds the selected channels
  property p_pin_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!align_pin_n_i && !align_pd_o) |=> (ch_static_o == $past(align_sel_i));
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("pin low did not hold channels");
  // idle bit and pin leave outputs free
  property p_idle_free;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!st.act_ctrl[APDU_BIT_SOFT_ALIGN] && align_pin_n_i) |=> (ch_static_o == '0);
  endproperty
  a_idle_free: assert property (p_idle_free)
    else $error("channels held with alignment idle");
  // start is a single-cycle pulse
  property p_start_pulse;
    @(posedge clk_i) disable iff (sys_rst_i)
      align_start_o |=> !align_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("alignment start longer than one cycle");
  // fall of the effective level starts alignment
  property p_start_after_fall;
    @(posedge clk_i) disable iff (sys_rst_i)
      ($fell(soft_align_eff) && !align_pd_o) |=> align_start_o;
  endproperty
  a_start_after_fall: assert property (p_start_after_fall)
    else $error("falling alignment level gave no start");
endmodule : apdu_regs
`default_nettype wire

/* File: test/tb_top.sv */
// testbench: register bank for alignment power-down, soft alignment and update-all
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb_top
  import apdu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic hreadyout_o, hresp_o, align_pin_n_i = 1'b1, align_pd_o, ref_pd_o;
  logic align_start_o, update_pulse_o;
  logic [7:0] align_sel_i = 8'hA5, ch_static_o;
  int fail_count = 0, checked = 0;
  localparam logic [31:0] A_CTRL = {20'h0, APDU_ADDR_PWR_CTRL};
  localparam logic [31:0] A_UPD = {20'h0, APDU_ADDR_UPDATE};
  apdu_regs #(.NUM_CH(8)) u_apdu_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .align_pin_n_i(align_pin_n_i),
    .align_sel_i(align_sel_i), .align_pd_o(align_pd_o), .ref_pd_o(ref_pd_o),
    .ch_static_o(ch_static_o), .align_start_o(align_start_o),
    .update_pulse_o(update_pulse_o));
  // clock of 10 ns
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // wait for hready sampled high, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 50);
    if (n >= 50) begin fail_count++; $display("BAD t=%0t got=%0h exp=%0h", $time, 0, 1); end
  endtask
  // one AHB-Lite single word transfer, read data taken at the data phase end
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel_i <= 1'b1; haddr_i <= a; htrans_i <= 2'h2; hwrite_i <= wr;
    wait_ready();
    htrans_i <= 2'h0; hwdata_i <= d;
    wait_ready();
    rd = hrdata_o;
    `CHK(hresp_o, 1'b0)
  endtask
  // wait for a one-cycle pulse and see it drop after one cycle
  task automatic pulse(ref logic s);
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (s !== 1'b1 && n < 20);
    `CHK(s, 1'b1)
    @(posedge clk_i);
    `CHK(s, 1'b0)
  endtask
  task automatic update();
    bus(1'b1, A_UPD, 32'h1);
    pulse(update_pulse_o);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset values and unmapped word
  task automatic t_reset();
    bus(1'b0, A_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b0, A_UPD, 32'h0);
    `CHK(rd, 32'h0)
    `CHK({align_pd_o, ref_pd_o, ch_static_o, align_start_o}, 11'h0)
    bus(1'b1, A_CTRL + 32'h4, 32'hFFFFFFFF);
    bus(1'b0, A_CTRL + 32'h4, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  // power-down bits take effect only on update-all, which clears itself
  task automatic t_power();
    bus(1'b1, A_CTRL, 32'h6);
    repeat (3) @(posedge clk_i);
    `CHK({align_pd_o, ref_pd_o}, 2'b00)
    update();
    #1;
    `CHK({align_pd_o, ref_pd_o}, 2'b11)
    bus(1'b0, A_UPD, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b0, A_CTRL, 32'h0);
    `CHK(rd, 32'h6)
    bus(1'b1, A_CTRL, 32'h0);
    update();
    #1;
    `CHK({align_pd_o, ref_pd_o}, 2'b00)
  endtask
  // soft alignment level holds channels, its fall starts alignment
  task automatic t_soft();
    bus(1'b1, A_CTRL, 32'h1);
    update();
    repeat (2) @(posedge clk_i);
    `CHK(ch_static_o, 8'hA5)
    align_sel_i <= 8'h3C;
    repeat (2) @(posedge clk_i);
    `CHK(ch_static_o, 8'h3C)
    bus(1'b1, A_CTRL, 32'h0);
    bus(1'b1, A_UPD, 32'h1);
    pulse(align_start_o);
    `CHK(ch_static_o, 8'h00)
    `CHK(align_start_o, 1'b0)
  endtask
  // pin low acts as soft bit high
  task automatic t_pin();
    align_pin_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK(ch_static_o, 8'h3C)
    align_pin_n_i <= 1'b1;
    pulse(align_start_o);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_power();
    t_soft();
    t_pin();
    test_done();
  end
  // watchdog well beyond the expected run
  initial begin
    #50000;
    fail_count++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
